/* rtl/annp_pkg.sv */
// package: register map, field positions and reset values for the next-page register set
package annp_pkg;

    localparam logic [4:0]  ANNP_ADDR_EXPANSION  = 5'h06;
    localparam logic [4:0]  ANNP_ADDR_NP_TX      = 5'h07;
    localparam logic [4:0]  ANNP_ADDR_PARTNER_NP = 5'h08;

    // expansion register bit positions
    localparam int          EXP_PD_FAULT         = 4;
    localparam int          EXP_LP_NP_ABLE       = 3;
    localparam int          EXP_NP_ABLE          = 2;
    localparam int          EXP_PAGE_RX          = 1;
    localparam int          EXP_LP_AN_ABLE       = 0;

    // next-page code word bit positions
    localparam int          NP_MORE              = 15;
    localparam int          NP_ACK               = 14;
    localparam int          NP_MSG               = 13;
    localparam int          NP_ACK2              = 12;
    localparam int          NP_TOGGLE            = 11;
    localparam int          NP_CODE_MSB          = 10;

    localparam logic [10:0] NP_TX_CODE_RESET     = 11'h001;
    localparam logic        NP_TX_MSG_RESET      = 1'b1;
    localparam logic        EXP_NP_ABLE_RESET    = 1'b1;
    localparam logic [15:0] ANNP_ZERO_WORD       = 16'h0000;

    // management access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } annp_mgmt_req_t;

    // condition and event inputs from the autonegotiation engine
    typedef struct packed {
        logic        pd_fault;
        logic        lp_np_able;
        logic        local_np_able;
        logic        page_rx;
        logic        lp_an_able;
    } annp_an_status_t;

    // one received next-page code word
    typedef struct packed {
        logic        load;
        logic [15:0] word;
    } annp_rx_page_t;

endpackage

/* rtl/annp_regs.sv */
// autonegotiation expansion, next-page transmit and partner next-page registers
// What this block does
// - expansion bit 4: parallel-detect fault, latched high
// - expansion bit 3: partner next-page able
// - expansion bit 2: local next-page able, default one
// - expansion bit 1: page received, latched high
// - expansion bit 0: partner autonegotiation able
// - transmit bit 15: more pages, writable, reset zero
// - transmit bit 13: message page, default one
// - transmit bit 12: acknowledge-two, writable, reset zero
// - transmit bit 11: read-only inverse of previous toggle
// - transmit code 10:0 reset one; bit 14 zero
// - partner bits 15,14,11 read-only, reset zero
// - partner bit 15 zero means last page
// - partner bits 13,12,10:0 writable, reset zero
// - acknowledge-two zero means cannot comply
// - toggle zero means previous was one; 15:5 reserved
`timescale 1ns/1ps

module annp_regs
    import annp_pkg::*;
(
    // clock and reset
    input  wire logic            clk_sys_i,
    input  wire logic            nrst_i,
    // management access
    input  wire annp_mgmt_req_t  mgmt_req_i,
    output logic [15:0]          mgmt_rdata_o,
    output logic                 mgmt_rvalid_o,
    // autonegotiation engine side
    input  wire annp_an_status_t an_status_i,
    input  wire annp_rx_page_t   rx_page_i,
    input  wire logic            tx_page_sent_i,
    output logic [15:0]          tx_code_word_o
);

    logic        rd_exp;
    logic        wr_tx;
    logic        wr_lp;
    logic        pd_fault_lh;
    logic        np_able_lh;
    logic        page_rx_lh;
    logic        tx_more;
    logic        tx_msg;
    logic        tx_ack2;
    logic        tx_toggle;
    logic [10:0] tx_code;
    logic        lp_more;
    logic        lp_ack;
    logic        lp_msg;
    logic        lp_ack2;
    logic        lp_toggle;
    logic [10:0] lp_code;
    logic [15:0] exp_word;
    logic [15:0] tx_word;
    logic [15:0] lp_word;
    logic [15:0] next_rdata;

    assign rd_exp = mgmt_req_i.rd && (mgmt_req_i.addr == ANNP_ADDR_EXPANSION);
    assign wr_tx  = mgmt_req_i.wr && (mgmt_req_i.addr == ANNP_ADDR_NP_TX);
    assign wr_lp  = mgmt_req_i.wr && (mgmt_req_i.addr == ANNP_ADDR_PARTNER_NP);

    // latching flags: a set in the read cycle wins, so no event is lost
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pd_fault_lh <= 1'b0;
            np_able_lh  <= EXP_NP_ABLE_RESET;
            page_rx_lh  <= 1'b0;
        end else begin
            if (an_status_i.pd_fault) begin
                pd_fault_lh <= 1'b1;
            end else if (rd_exp) begin
                pd_fault_lh <= 1'b0;
            end
            if (an_status_i.local_np_able) begin
                np_able_lh <= 1'b1;
            end else if (rd_exp) begin
                np_able_lh <= 1'b0;
            end
            if (an_status_i.page_rx || rx_page_i.load) begin
                page_rx_lh <= 1'b1;
            end else if (rd_exp) begin
                page_rx_lh <= 1'b0;
            end
        end
    end

    // transmit next-page fields written by management
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_more <= 1'b0;
            tx_msg  <= NP_TX_MSG_RESET;
            tx_ack2 <= 1'b0;
            tx_code <= NP_TX_CODE_RESET;
        end else if (wr_tx) begin
            tx_more <= mgmt_req_i.wdata[NP_MORE];
            tx_msg  <= mgmt_req_i.wdata[NP_MSG];
            tx_ack2 <= mgmt_req_i.wdata[NP_ACK2];
            tx_code <= mgmt_req_i.wdata[NP_CODE_MSB:0];
        end
    end

    // toggle flips after each sent code word; software cannot write it
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_toggle <= 1'b0;
        end else if (tx_page_sent_i) begin
            tx_toggle <= ~tx_toggle;
        end
    end

    // partner word: engine loads it; writable fields also take management writes
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lp_more   <= 1'b0;
            lp_ack    <= 1'b0;
            lp_toggle <= 1'b0;
            lp_msg    <= 1'b0;
            lp_ack2   <= 1'b0;
            lp_code   <= '0;
        end else if (rx_page_i.load) begin
            lp_more   <= rx_page_i.word[NP_MORE];
            lp_ack    <= rx_page_i.word[NP_ACK];
            lp_toggle <= rx_page_i.word[NP_TOGGLE];
            lp_msg    <= rx_page_i.word[NP_MSG];
            lp_ack2   <= rx_page_i.word[NP_ACK2];
            lp_code   <= rx_page_i.word[NP_CODE_MSB:0];
        end else if (wr_lp) begin
            lp_msg    <= mgmt_req_i.wdata[NP_MSG];
            lp_ack2   <= mgmt_req_i.wdata[NP_ACK2];
            lp_code   <= mgmt_req_i.wdata[NP_CODE_MSB:0];
        end
    end

    always_comb begin
        exp_word                 = ANNP_ZERO_WORD;
        exp_word[EXP_PD_FAULT]   = pd_fault_lh;
        exp_word[EXP_LP_NP_ABLE] = an_status_i.lp_np_able;
        exp_word[EXP_NP_ABLE]    = np_able_lh;
        exp_word[EXP_PAGE_RX]    = page_rx_lh;
        exp_word[EXP_LP_AN_ABLE] = an_status_i.lp_an_able;
    end

    // bit 14 of the transmit word stays zero
    assign tx_word = {tx_more, 1'b0, tx_msg, tx_ack2, tx_toggle, tx_code};
    assign lp_word = {lp_more, lp_ack, lp_msg, lp_ack2, lp_toggle, lp_code};

    always_comb begin
        next_rdata = ANNP_ZERO_WORD;
        if (mgmt_req_i.rd) begin
            unique case (mgmt_req_i.addr)
                ANNP_ADDR_EXPANSION:  next_rdata = exp_word;
                ANNP_ADDR_NP_TX:      next_rdata = tx_word;
                ANNP_ADDR_PARTNER_NP: next_rdata = lp_word;
                default:              next_rdata = ANNP_ZERO_WORD;
            endcase
        end
    end

    // read data registered: it shows flags before the read clears them
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mgmt_rdata_o  <= ANNP_ZERO_WORD;
            mgmt_rvalid_o <= 1'b0;
        end else begin
            mgmt_rdata_o  <= next_rdata;
            mgmt_rvalid_o <= mgmt_req_i.rd;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_code_word_o <= {1'b0, 1'b0, NP_TX_MSG_RESET, 1'b0, 1'b0, NP_TX_CODE_RESET};
        end else begin
            tx_code_word_o <= tx_word;
        end
    end

endmodule

/* verification/annp_mgmt_model.sv */
// management controller model issuing single register transfers
`timescale 1ns/1ps
module annp_mgmt_model
    import annp_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] rdata_i,
    output annp_mgmt_req_t   req_o
);
    initial req_o = '0;
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
        @(negedge clk_sys_i);
        req_o = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge clk_sys_i);
        q = rdata_i;
        // released lines show no stale value
        req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

/* verification/annp_regs_properties.sv */
// assertion checker for the next-page register set
`timescale 1ns/1ps
module annp_regs_properties
    import annp_pkg::*;
(
    input wire logic            clk_sys_i,
    input wire logic            nrst_i,
    input wire annp_mgmt_req_t  mgmt_req_i,
    input wire logic [15:0]     mgmt_rdata_o,
    input wire logic            mgmt_rvalid_o,
    input wire annp_an_status_t an_status_i,
    input wire annp_rx_page_t   rx_page_i,
    input wire logic            tx_page_sent_i,
    input wire logic [15:0]     tx_code_word_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    wire logic rd = mgmt_req_i.rd;
    wire logic r6 = rd && mgmt_req_i.addr == ANNP_ADDR_EXPANSION;
    wire logic r8 = rd && mgmt_req_i.addr == ANNP_ADDR_PARTNER_NP;
    property p_rv; rd |=> mgmt_rvalid_o; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_idle; !rd |=> !mgmt_rvalid_o && mgmt_rdata_o == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_res; r6 |=> mgmt_rdata_o[15:5] == 11'h000; endproperty
    a_res: assert property (p_res) else $error("reserved bits set");
    property p_live; r6 |=> mgmt_rdata_o[3] == $past(an_status_i.lp_np_able)
        && mgmt_rdata_o[0] == $past(an_status_i.lp_an_able); endproperty
    a_live: assert property (p_live) else $error("partner ability bits wrong");
    property p_pd; an_status_i.pd_fault ##1 !r6 ##1 r6 |=> mgmt_rdata_o[4]; endproperty
    a_pd: assert property (p_pd) else $error("fault flag not latched");
    property p_pg; rx_page_i.load ##1 !r6 ##1 r6 |=> mgmt_rdata_o[1]; endproperty
    a_pg: assert property (p_pg) else $error("page flag not latched");
    property p_np; rx_page_i.load ##1 (!rx_page_i.load && !mgmt_req_i.wr) ##1 (r8 && !rx_page_i.load && !mgmt_req_i.wr)
        |=> mgmt_rdata_o == $past(rx_page_i.word, 3); endproperty
    a_np: assert property (p_np) else $error("received page not held");
    property p_tog; tx_page_sent_i |=> ##1 tx_code_word_o[11] != $past(tx_code_word_o[11]); endproperty
    a_tog: assert property (p_tog) else $error("toggle did not flip");
    property p_b14; tx_code_word_o[14] == 1'b0; endproperty
    a_b14: assert property (p_b14) else $error("reserved transmit bit set");
endmodule

bind annp_regs annp_regs_properties u_annp_regs_properties (.clk_sys_i, .nrst_i, .mgmt_req_i,
    .mgmt_rdata_o, .mgmt_rvalid_o, .an_status_i, .rx_page_i, .tx_page_sent_i, .tx_code_word_o);

/* verification/annp_regs_tb.sv */
// self-checking bench for the next-page register set
`timescale 1ns/1ps
module annp_regs_tb;
    import annp_pkg::*;
    logic            clk_sys_i = 1'b0;
    logic            nrst_i = 1'b0;
    annp_mgmt_req_t  req;
    logic [15:0]     rdata, txw, q, d, p = 16'h0000;
    logic            rv, sent = 1'b0, tog = 1'b0;
    annp_an_status_t st = '0;
    annp_rx_page_t   rxp = '0;
    int              failures = 0, check_count = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    annp_regs u_annp_regs (.clk_sys_i, .nrst_i, .mgmt_req_i(req), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rv),
        .an_status_i(st), .rx_page_i(rxp), .tx_page_sent_i(sent), .tx_code_word_o(txw));
    annp_mgmt_model u_annp_mgmt_model (.clk_sys_i, .rdata_i(rdata), .req_o(req));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [4:0] a, input logic [15:0] e);
        u_annp_mgmt_model.xfer(1'b0, a, 16'h0000, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        u_annp_mgmt_model.xfer(1'b1, a, v, q);
    endtask
    function automatic logic [15:0] exp_tx(input logic [15:0] v, input logic t);
        return (v & 16'hb7ff) | {4'h0, t, 11'h000};
    endfunction
    task automatic summarize;
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #100us;
        failures++;
        summarize;
    end
    initial begin
        void'($urandom(32'hc4c6_0a6d));
        repeat (12) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        chk(txw, 16'h2001);
        rc(ANNP_ADDR_EXPANSION, 16'h0004);
        rc(ANNP_ADDR_EXPANSION, 16'h0000);
        rc(ANNP_ADDR_PARTNER_NP, 16'h0000);
        rc(ANNP_ADDR_NP_TX, 16'h2001);
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 16'hffff : 16'($urandom);
            wr(ANNP_ADDR_NP_TX, d);
            sent = d[0];
            @(negedge clk_sys_i);
            sent = 1'b0;
            tog ^= d[0];
            rc(ANNP_ADDR_NP_TX, exp_tx(d, tog));
            wr(ANNP_ADDR_PARTNER_NP, d);
            rc(ANNP_ADDR_PARTNER_NP, (d & 16'h37ff) | (p & 16'hc800));
            st.lp_np_able = d[3];
            st.lp_an_able = d[1];
            rxp = '{load: 1'b1, word: ~d};
            p = ~d;
            @(negedge clk_sys_i);
            rxp.load = 1'b0;
            rc(ANNP_ADDR_PARTNER_NP, p);
            rc(ANNP_ADDR_EXPANSION, {11'h000, 1'b0, d[3], 1'b0, 1'b1, d[1]});
            st.pd_fault = 1'b1;
            @(negedge clk_sys_i);
            st.pd_fault = 1'b0;
            rc(ANNP_ADDR_EXPANSION, {11'h000, 1'b1, d[3], 2'b00, d[1]});
        end
        wr(ANNP_ADDR_EXPANSION, 16'hffff);
        rc(ANNP_ADDR_EXPANSION, {12'h000, d[3], 2'b00, d[1]});
        st.local_np_able = 1'b1;
        rc(ANNP_ADDR_EXPANSION, {11'h000, 1'b0, d[3], 1'b1, 1'b0, d[1]});
        st.local_np_able = 1'b0;
        rc(5'h1f, 16'h0000);
        summarize;
    end
endmodule
